// *** logic_array_consts.vh ***
// Summary of operation
// R1: low-half first feedback: 00 is element 0/15
// R2: high-half first feedback: 00 is element 8/7
// R3: second feedback picks odd elements of half
// R4: enable bit gates array conversion start
// R5: trigger source field equals element number
// R6: software input bit n feeds element n
// R7: output snapshot bit n is element n
// R8: output snapshot refreshes every cycle
// R9: lock bit writable once after reset
// R10: lock blocks config writes except software input
// R11: config 10:9 first select, 8:7 second
// R12: config bit 6 picks feedback or software bit
// R13: blocked writes silent; all registers reset to defaults
`ifndef LOGIC_ARRAY_CONSTS_VH
`define LOGIC_ARRAY_CONSTS_VH

`define ELEM_CFG_BASE 32'hFFFF0B00
`define ELEM_CFG_STRIDE 32'h00000004
`define ADC_TRIG_SEL_ADDR 32'hFFFF0B48
`define SW_INPUT_ADDR 32'hFFFF0B4C
`define OUT_SNAP_ADDR 32'hFFFF0B50
`define CFG_LOCK_ADDR 32'hFFFF0B54

`define ELEM_CFG_RESET 11'h000
`define ADC_TRIG_SEL_RESET 5'h00
`define SW_INPUT_RESET 16'h0000
`define CFG_LOCK_RESET 1'h0

`define CFG_FB0_HI 10
`define CFG_FB0_LO 9
`define CFG_FB1_HI 8
`define CFG_FB1_LO 7
`define CFG_A_SEL_BIT 6
`define CFG_B_SEL_BIT 5
`define CFG_LUT_HI 4
`define CFG_LUT_LO 1
`define CFG_BYPASS_BIT 0
`define CFG_WIDTH 11

`define ADC_EN_BIT 4
`define ADC_SRC_HI 3
`define ADC_SRC_LO 0
`define LOCK_BIT 0

`endif

// *** logic_array_routing_and_lock.v ***
`include "logic_array_consts.vh"

module logic_array_routing_and_lock #(
   parameter ELEMS = 16
) (
   input wire clock,
   input wire arst_n,
   input wire [31:0] address,
   input wire [31:0] wdata,
   input wire write_strobe,
   input wire read_strobe,
   input wire [ELEMS-1:0] elem_pin_in,
   output reg [31:0] rdata,
   output reg [ELEMS-1:0] elem_out,
   output reg adc_start,
   output reg config_locked
);

   localparam SEL_NONE = 3'h0;
   localparam SEL_ELEM = 3'h1;
   localparam SEL_ADC = 3'h2;
   localparam SEL_SW = 3'h3;
   localparam SEL_SNAP = 3'h4;
   localparam SEL_LOCK = 3'h5;

   // first feedback: code 00 takes the half's first element, except for
   // that element itself, which wraps to the other half's last element;
   // the other codes pick the even elements 2, 4 and 6 of the half
   function [3:0] fb0_src;
      input [3:0] n;
      input [1:0] code;
      reg [3:0] base;
      begin
         base = {n[3], 3'h0};
         case (code)
            2'h0: begin
               if (n == base) begin
                  fb0_src = base - 4'h1; // see R1 see R2
               end else begin
                  fb0_src = base; // see R1 see R2
               end
            end
            2'h1: begin
               fb0_src = base + 4'h2; // see R1 see R2
            end
            2'h2: begin
               fb0_src = base + 4'h4; // see R1 see R2
            end
            2'h3: begin
               fb0_src = base + 4'h6; // see R1 see R2
            end
            default: begin
               fb0_src = base;
            end
         endcase
      end
   endfunction

   // second feedback always picks an odd element of the same half
   function [3:0] fb1_src;
      input [3:0] n;
      input [1:0] code;
      reg [3:0] base;
      begin
         base = {n[3], 3'h0};
         case (code)
            2'h0: begin
               fb1_src = base + 4'h1; // see R3
            end
            2'h1: begin
               fb1_src = base + 4'h3; // see R3
            end
            2'h2: begin
               fb1_src = base + 4'h5; // see R3
            end
            2'h3: begin
               fb1_src = base + 4'h7; // see R3
            end
            default: begin
               fb1_src = base + 4'h1;
            end
         endcase
      end
   endfunction

   // two-input lookup: the four table bits are the outputs for the input
   // pairs {a,b} = 11, 10, 01, 00 from the top bit down
   function lut_eval;
      input [3:0] truth;
      input a;
      input b;
      begin
         case ({a, b})
            2'h0: begin
               lut_eval = truth[0];
            end
            2'h1: begin
               lut_eval = truth[1];
            end
            2'h2: begin
               lut_eval = truth[2];
            end
            2'h3: begin
               lut_eval = truth[3];
            end
            default: begin
               lut_eval = 1'b0;
            end
         endcase
      end
   endfunction

   function is_elem_addr;
      input [31:0] a;
      reg [31:0] off;
      begin
         off = a - `ELEM_CFG_BASE;
         is_elem_addr = (off[31:6] == 26'h0) && (off[1:0] == 2'h0);
      end
   endfunction

   // one decode serves both the write enables and the read mux, so the
   // two can never disagree about which register an address names
   function [2:0] reg_sel;
      input [31:0] a;
      begin
         if (is_elem_addr(a)) begin
            reg_sel = SEL_ELEM;
         end else if (a == `ADC_TRIG_SEL_ADDR) begin
            reg_sel = SEL_ADC;
         end else if (a == `SW_INPUT_ADDR) begin
            reg_sel = SEL_SW;
         end else if (a == `OUT_SNAP_ADDR) begin
            reg_sel = SEL_SNAP;
         end else if (a == `CFG_LOCK_ADDR) begin
            reg_sel = SEL_LOCK;
         end else begin
            reg_sel = SEL_NONE;
         end
      end
   endfunction

   reg [`CFG_WIDTH-1:0] cfg_q [0:ELEMS-1];
   reg [4:0] adc_sel_q;
   reg [15:0] sw_in_q;
   reg lock_q;
   reg lock_written_q;
   reg [ELEMS-1:0] ff_q;

   reg [ELEMS-1:0] lut_d;
   reg [ELEMS-1:0] comb_out;
   reg [31:0] rdata_d;
   reg [31:0] elem_off;
   reg [3:0] src0;
   reg [3:0] src1;
   reg a_bit;
   reg b_bit;
   reg [3:0] lut;
   reg [2:0] sel;
   reg wr_elem;
   reg wr_adc;
   reg wr_sw;
   reg wr_lock;
   integer i;
   integer j;

   always @* begin
      elem_off = address - `ELEM_CFG_BASE;
      sel = reg_sel(address);
   end

   // feedback reads the registered outputs, so a looped configuration
   // settles one clock later instead of forming a combinational loop
   always @* begin
      lut_d = {ELEMS{1'b0}};
      comb_out = {ELEMS{1'b0}};
      src0 = 4'h0;
      src1 = 4'h0;
      a_bit = 1'b0;
      b_bit = 1'b0;
      lut = 4'h0;
      for (i = 0; i < ELEMS; i = i + 1) begin
         src0 = fb0_src(i[3:0], cfg_q[i][`CFG_FB0_HI:`CFG_FB0_LO]); // see R11
         src1 = fb1_src(i[3:0], cfg_q[i][`CFG_FB1_HI:`CFG_FB1_LO]); // see R11
         if (cfg_q[i][`CFG_A_SEL_BIT]) begin
            a_bit = elem_out[src0]; // see R12
         end else begin
            a_bit = sw_in_q[i]; // see R6 see R12
         end
         if (cfg_q[i][`CFG_B_SEL_BIT]) begin
            b_bit = elem_pin_in[i];
         end else begin
            b_bit = elem_out[src1];
         end
         lut = cfg_q[i][`CFG_LUT_HI:`CFG_LUT_LO];
         lut_d[i] = lut_eval(lut, a_bit, b_bit);
         if (cfg_q[i][`CFG_BYPASS_BIT]) begin
            comb_out[i] = lut_d[i];
         end else begin
            comb_out[i] = ff_q[i];
         end
      end
   end

   // the lock register is write-only and reads as zero
   always @* begin
      rdata_d = 32'h00000000;
      case (sel)
         SEL_ELEM: begin
            rdata_d = {21'h000000, cfg_q[elem_off[5:2]]};
         end
         SEL_ADC: begin
            rdata_d = {27'h0000000, adc_sel_q};
         end
         SEL_SW: begin
            rdata_d = {16'h0000, sw_in_q};
         end
         SEL_SNAP: begin
            rdata_d = {16'h0000, elem_out}; // see R7
         end
         default: begin
            rdata_d = 32'h00000000;
         end
      endcase
   end

   // write decodes; locked writes to element configs and trigger select complete normally but store nothing
   always @* begin
      wr_elem = write_strobe && (sel == SEL_ELEM) && !lock_q; // see R10
      wr_adc = write_strobe && (sel == SEL_ADC) && !lock_q; // see R10
      wr_sw = write_strobe && (sel == SEL_SW); // see R10
      wr_lock = write_strobe && (sel == SEL_LOCK) && !lock_written_q; // see R9
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (j = 0; j < ELEMS; j = j + 1) begin
            cfg_q[j] <= `ELEM_CFG_RESET; // see R13
         end
      end else if (wr_elem) begin
         cfg_q[elem_off[5:2]] <= wdata[`CFG_WIDTH-1:0]; // see R10
      end
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         adc_sel_q <= `ADC_TRIG_SEL_RESET; // see R13
      end else if (wr_adc) begin
         adc_sel_q <= wdata[4:0]; // see R10 see R13
      end
   end

   // the software input stays writable while locked
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sw_in_q <= `SW_INPUT_RESET; // see R13
      end else if (wr_sw) begin
         sw_in_q <= wdata[15:0]; // see R6 see R10
      end
   end

   // any value written consumes the single lock write, so a zero written
   // first leaves the configuration open until the next reset
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lock_q <= `CFG_LOCK_RESET; // see R13
         lock_written_q <= 1'b0;
      end else if (wr_lock) begin
         lock_q <= wdata[`LOCK_BIT]; // see R9
         lock_written_q <= 1'b1; // see R9
      end
   end

   // element flip-flops run on the bus clock
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ff_q <= {ELEMS{1'b0}};
      end else begin
         ff_q <= lut_d;
      end
   end

   // the snapshot is the registered output itself, refreshed every cycle
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         elem_out <= {ELEMS{1'b0}};
      end else begin
         elem_out <= comb_out; // see R8
      end
   end

   // the start level is taken from the value that elem_out gets, so the
   // selected output and the start line change on the same edge
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         adc_start <= 1'b0;
      end else begin
         adc_start <= adc_sel_q[`ADC_EN_BIT] &
            comb_out[adc_sel_q[`ADC_SRC_HI:`ADC_SRC_LO]]; // see R4 see R5
      end
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         config_locked <= 1'b0;
      end else begin
         config_locked <= lock_q; // see R10
      end
   end

   // read data stands only in the cycle after the strobe, zero otherwise
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 32'h00000000;
      end else if (read_strobe) begin
         rdata <= rdata_d;
      end else begin
         rdata <= 32'h00000000;
      end
   end

endmodule

// *** adc_start_sink.sv ***
module adc_start_sink (
   input logic clock,
   input logic arst_n,
   input logic start,
   output logic [7:0] conversions
);
   timeunit 1ns;
   timeprecision 1ps;
   logic start_q;
   // a held start level begins one conversion only
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         start_q <= 1'b0;
         conversions <= 8'h00;
      end else begin
         start_q <= start;
         if (start && !start_q) conversions <= conversions + 8'h01;
      end
   end
endmodule

// *** logic_array_properties.sv ***
`include "logic_array_consts.vh"
module logic_array_checks #(parameter ELEMS = 16) (
   input logic clock,
   input logic arst_n,
   input logic [31:0] address,
   input logic [31:0] wdata,
   input logic write_strobe,
   input logic read_strobe,
   input logic [31:0] rdata,
   input logic [ELEMS-1:0] elem_out,
   input logic adc_start,
   input logic config_locked
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic used_q;
   logic val_q;
   wire lw = write_strobe && address == `CFG_LOCK_ADDR;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         used_q <= 1'b0;
         val_q <= 1'b0;
      end else if (lw && !used_q) begin
         used_q <= 1'b1;
         val_q <= wdata[0];
      end
   end
   a_rd_idle: assert property (!read_strobe |=> rdata == 32'h0)
      else $error("rdata not idle");
   a_snap_upper: assert property (read_strobe && address == `OUT_SNAP_ADDR |=>
      rdata[31:16] == 16'h0) else $error("snapshot upper bits");
   a_unmapped_rd: assert property (read_strobe && address[31:8] != 24'hFFFF0B |=>
      rdata == 32'h0) else $error("unmapped read");
   a_adc_src: assert property (adc_start |-> elem_out != '0)
      else $error("start without source");
   a_lock_take: assert property ($rose(used_q) |=> config_locked == val_q)
      else $error("lock not taken");
   a_lock_hold: assert property (used_q && $past(used_q, 2) |-> $stable(config_locked))
      else $error("lock changed");
   a_lock_off: assert property (!used_q |-> !config_locked)
      else $error("lock without write");
   a_sw_back: assert property (write_strobe && address == `SW_INPUT_ADDR ##1 read_strobe
      && address == `SW_INPUT_ADDR |=> rdata == {16'h0, $past(wdata[15:0], 2)})
      else $error("sw input readback");
   c_adc: cover property (adc_start);
   c_lock: cover property (config_locked);
   c_snap: cover property (read_strobe && address == `OUT_SNAP_ADDR);
endmodule
bind logic_array_routing_and_lock logic_array_checks #(.ELEMS(ELEMS)) checks_i (.*);

// *** logic_array_routing_and_lock_tb.sv ***
`include "logic_array_consts.vh"
module logic_array_routing_and_lock_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [31:0] address = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic write_strobe = 1'b0;
   logic read_strobe = 1'b0;
   logic [15:0] pins = 16'h0;
   logic [31:0] rdata;
   logic [15:0] elem_out;
   logic adc_start;
   logic config_locked;
   logic [7:0] conv;
   int miscompares = 0;
   int checks = 0;
   localparam logic [31:0] CB = `ELEM_CFG_BASE;
   always #2.5 clock = ~clock;
   logic_array_routing_and_lock logic_array_routing_and_lock_i (.clock(clock),
      .arst_n(arst_n), .address(address), .wdata(wdata), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .elem_pin_in(pins), .rdata(rdata), .elem_out(elem_out),
      .adc_start(adc_start), .config_locked(config_locked));
   adc_start_sink adc_start_sink_i (.clock(clock), .arst_n(arst_n), .start(adc_start),
      .conversions(conv));
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      @(posedge clock) {address, read_strobe} <= {a, 1'b1};
      @(posedge clock) read_strobe <= 1'b0;
      @(negedge clock) chk(rdata, e);
   endtask
   // write then read back with no gap, so every write except to the write-only lock register is seen to land or not
   task wrd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge clock) {address, wdata, write_strobe} <= {a, d, 1'b1};
      @(posedge clock) {write_strobe, read_strobe} <= 2'b01;
      @(posedge clock) read_strobe <= 1'b0;
      @(negedge clock) chk(rdata, e);
   endtask
   task test_done;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clock);
      miscompares++;
      test_done;
   end
   initial begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      rd(`ADC_TRIG_SEL_ADDR, 32'h0);
      rd(`OUT_SNAP_ADDR, 32'h0);
      wrd(CB, 32'h19, 32'h19);
      wrd(CB + 32'h1C, 32'h59, 32'h59);
      wrd(CB + 32'h20, 32'h59, 32'h59);
      wrd(CB + 32'h24, 32'h59, 32'h59);
      wrd(CB + 32'h28, 32'h15, 32'h15);
      wrd(`SW_INPUT_ADDR, 32'hFFFF0001, 32'h1);
      repeat (8) @(posedge clock);
      rd(`OUT_SNAP_ADDR, 32'h0781);
      wrd(`ADC_TRIG_SEL_ADDR, 32'h1A, 32'h1A);
      chk({31'h0, adc_start}, 32'h1);
      wrd(`ADC_TRIG_SEL_ADDR, 32'h0A, 32'h0A);
      chk({31'h0, adc_start}, 32'h0);
      wrd(`CFG_LOCK_ADDR, 32'h1, 32'h0);
      wrd(`ADC_TRIG_SEL_ADDR, 32'h1A, 32'h0A);
      wrd(CB + 32'h28, 32'h0, 32'h15);
      wrd(`SW_INPUT_ADDR, 32'h0, 32'h0);
      repeat (8) @(posedge clock);
      rd(`OUT_SNAP_ADDR, 32'h0);
      wrd(`CFG_LOCK_ADDR, 32'h0, 32'h0);
      chk({31'h0, config_locked}, 32'h1);
      rd(32'hFFFF0BFC, 32'h0);
      chk({24'h0, conv}, 32'h1);
      test_done;
   end
endmodule
